// ### design/jub_pkg.sv
// Shared constants and types of the JTAG to unit bus bridge
package jub_pkg;
   // Register and bus widths
   localparam int ADDR_W = 40;
   localparam int DATA_W = 64;
   localparam int RDSC_W = 65;
   localparam int IR_W = 4;
   localparam int LR_OFS_W = 8;

   // Instruction codes
   localparam logic [IR_W-1:0] IR_ADDR_LOAD = 4'h1;
   localparam logic [IR_W-1:0] IR_WDATA_LOAD = 4'h2;
   localparam logic [IR_W-1:0] IR_RDATA = 4'h3;
   localparam logic [IR_W-1:0] IR_START_WRITE = 4'h4;
   localparam logic [IR_W-1:0] IR_START_READ = 4'h5;
   localparam logic [IR_W-1:0] IR_ADDR_WRITE = 4'h6;
   localparam logic [IR_W-1:0] IR_DATA_WRITE = 4'h7;
   localparam logic [IR_W-1:0] IR_ADDR_READ = 4'h8;
   localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
   localparam logic [IR_W-1:0] IR_RESET = IR_BYPASS;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

   // Local register offsets
   localparam logic [LR_OFS_W-1:0] LR_CTRL = 8'h00;
   localparam logic [LR_OFS_W-1:0] LR_STATUS = 8'h08;
   localparam logic [LR_OFS_W-1:0] LR_HOLD_ADDR = 8'h10;
   localparam logic [LR_OFS_W-1:0] LR_HOLD_DATA = 8'h18;
   localparam logic [LR_OFS_W-1:0] LR_RDATA = 8'h20;

   // Local register fields and values
   localparam logic [DATA_W-1:0] CTRL_RST = 64'h0000_0000_0000_0001;
   localparam logic [DATA_W-1:0] UNDEF_RDATA = 64'hDEAD_0000_DEAD_0000;
   localparam int CTRL_EN_BIT = 0;
   localparam int ST_SENTINEL = 0;
   localparam int ST_RD_BUSY = 1;
   localparam int ST_REQ_PEND = 2;
   localparam int ST_IR_LSB = 8;

   // TAP controller states
   typedef enum logic [3:0] {
      TAP_EX2_DR = 4'h0, TAP_EX1_DR = 4'h1, TAP_SHIFT_DR = 4'h2, TAP_PAUSE_DR = 4'h3,
      TAP_SEL_IR = 4'h4, TAP_UPD_DR = 4'h5, TAP_CAP_DR = 4'h6, TAP_SEL_DR = 4'h7,
      TAP_EX2_IR = 4'h8, TAP_EX1_IR = 4'h9, TAP_SHIFT_IR = 4'hA, TAP_PAUSE_IR = 4'hB,
      TAP_IDLE = 4'hC, TAP_UPD_IR = 4'hD, TAP_CAP_IR = 4'hE, TAP_RESET = 4'hF
   } jub_tap_state_t;
endpackage

// ### design/jub_tap.sv
// TAP controller and instruction register of the bridge
`timescale 1ns/1ps
`default_nettype none
module jub_tap
   import jub_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Sampled JTAG pins
   input wire logic tck_rise,
   input wire logic tms,
   input wire logic tdi,
   // Controller view
   output jub_tap_state_t state,
   output logic [IR_W-1:0] ir,
   output logic ir_tdo,
   output logic cap_dr,
   output logic shift_dr,
   output logic upd_dr,
   output logic upd_ir
);
   typedef struct packed {
      jub_tap_state_t st;
      logic [IR_W-1:0] ir_sh;
      logic [IR_W-1:0] ir;
      logic cap_dr;
      logic upd_dr;
      logic upd_ir;
   } jub_tap_reg_t;

   jub_tap_reg_t s_q;
   jub_tap_reg_t s_d;
   jub_tap_state_t nxt;

   function automatic jub_tap_state_t next_state(input jub_tap_state_t c, input logic m);
      unique case (c)
         TAP_RESET: next_state = m ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: next_state = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: next_state = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: next_state = m ? TAP_EX1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: next_state = m ? TAP_EX1_DR : TAP_SHIFT_DR;
         TAP_EX1_DR: next_state = m ? TAP_UPD_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR: next_state = m ? TAP_EX2_DR : TAP_PAUSE_DR;
         TAP_EX2_DR: next_state = m ? TAP_UPD_DR : TAP_SHIFT_DR;
         TAP_UPD_DR: next_state = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: next_state = m ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: next_state = m ? TAP_EX1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: next_state = m ? TAP_EX1_IR : TAP_SHIFT_IR;
         TAP_EX1_IR: next_state = m ? TAP_UPD_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR: next_state = m ? TAP_EX2_IR : TAP_PAUSE_IR;
         TAP_EX2_IR: next_state = m ? TAP_UPD_IR : TAP_SHIFT_IR;
         TAP_UPD_IR: next_state = m ? TAP_SEL_DR : TAP_IDLE;
      endcase
   endfunction

   always_comb begin
      s_d = s_q;
      s_d.cap_dr = 1'b0;
      s_d.upd_dr = 1'b0;
      s_d.upd_ir = 1'b0;
      nxt = next_state(s_q.st, tms);
      if (tck_rise) begin
         if (s_q.st == TAP_SHIFT_IR) begin
            s_d.ir_sh = {tdi, s_q.ir_sh[IR_W-1:1]};
         end
         if (nxt == TAP_CAP_IR) begin
            s_d.ir_sh = IR_CAPTURE;
         end
         // Update pulses rise in the same cycle as the new instruction, so users see it settled
         if (nxt == TAP_UPD_IR) begin
            s_d.ir = s_q.ir_sh;
            s_d.upd_ir = 1'b1;
         end
         if (nxt == TAP_RESET) begin
            s_d.ir = IR_RESET;
         end
         s_d.cap_dr = (nxt == TAP_CAP_DR);
         s_d.upd_dr = (nxt == TAP_UPD_DR);
         s_d.st = nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.st <= TAP_RESET;
         s_q.ir <= IR_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign state = s_q.st;
   assign ir = s_q.ir;
   assign ir_tdo = s_q.ir_sh[0];
   assign cap_dr = s_q.cap_dr;
   assign shift_dr = tck_rise && (s_q.st == TAP_SHIFT_DR);
   assign upd_dr = s_q.upd_dr;
   assign upd_ir = s_q.upd_ir;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_ir_update: assert property (
      tck_rise && (s_q.st == TAP_EX1_IR) && tms |=> upd_ir && (ir == $past(s_q.ir_sh)))
      else $error("instruction not updated on update-ir");
endmodule
`default_nettype wire

// ### design/jub_slave.sv
// Unit bus slave path serving the bridge's local registers
`timescale 1ns/1ps
`default_nettype none
module jub_slave
   import jub_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Incoming request
   input wire logic req_vld,
   input wire logic req_rd,
   input wire logic [LR_OFS_W-1:0] req_ofs,
   input wire logic [DATA_W-1:0] req_data,
   // Read response
   output logic rsp_vld,
   output logic [DATA_W-1:0] rsp_data,
   input wire logic rsp_stall,
   // Register contents
   input wire logic [DATA_W-1:0] status,
   input wire logic [ADDR_W-1:0] hold_addr,
   input wire logic [DATA_W-1:0] hold_data,
   input wire logic [DATA_W-1:0] rdata,
   output logic [DATA_W-1:0] ctrl
);
   typedef struct packed {
      logic slot_vld;
      logic slot_rd;
      logic [LR_OFS_W-1:0] slot_ofs;
      logic [DATA_W-1:0] slot_data;
      logic rsp_vld;
      logic [DATA_W-1:0] rsp_data;
      logic [DATA_W-1:0] ctrl;
   } jub_slv_reg_t;

   jub_slv_reg_t s_q;
   jub_slv_reg_t s_d;
   logic consume;
   logic [DATA_W-1:0] rd_word;

   always_comb begin
      unique case (s_q.slot_ofs)
         LR_CTRL: rd_word = s_q.ctrl;
         LR_STATUS: rd_word = status;
         LR_HOLD_ADDR: rd_word = DATA_W'(hold_addr);
         LR_HOLD_DATA: rd_word = hold_data;
         LR_RDATA: rd_word = rdata;
         default: rd_word = UNDEF_RDATA;
      endcase
   end

   // One request slot only: a stall of even one cycle fills it and drops the rest
   assign consume = s_q.slot_vld && (!s_q.rsp_vld || !rsp_stall);

   always_comb begin
      s_d = s_q;
      if (s_q.rsp_vld && !rsp_stall) begin
         s_d.rsp_vld = 1'b0;
      end
      if (consume) begin
         s_d.slot_vld = 1'b0;
         if (s_q.slot_rd) begin
            s_d.rsp_vld = 1'b1;
            s_d.rsp_data = rd_word;
         end else if (s_q.slot_ofs == LR_CTRL) begin
            s_d.ctrl = s_q.slot_data;
         end
      end
      if (req_vld && (!s_q.slot_vld || consume)) begin
         s_d.slot_vld = 1'b1;
         s_d.slot_rd = req_rd;
         s_d.slot_ofs = req_ofs;
         s_d.slot_data = req_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.ctrl <= CTRL_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rsp_vld = s_q.rsp_vld;
   assign rsp_data = s_q.rsp_data;
   assign ctrl = s_q.ctrl;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_undef_read_ack: assert property (
      consume && s_q.slot_rd && (s_q.slot_ofs > LR_RDATA) |=> rsp_vld && rsp_data == UNDEF_RDATA)
      else $error("undefined read not acknowledged");
   chk_undef_write_nop: assert property (
      consume && !s_q.slot_rd && (s_q.slot_ofs != LR_CTRL) |=> $stable(ctrl))
      else $error("undefined write changed a register");
   chk_stall_drop: assert property (
      s_q.rsp_vld && rsp_stall && s_q.slot_vld |=> $stable(s_q.slot_ofs) && $stable(s_q.slot_rd))
      else $error("request slot overwritten during stall");
endmodule
`default_nettype wire

// ### design/jub_bridge.sv
// JTAG to unit bus bridge: scan registers, holding registers, bus master and slave
`timescale 1ns/1ps
`default_nettype none
module jub_bridge
   import jub_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // JTAG pins
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   output logic TDO,
   output logic TDO_OE,
   // Master requests toward the hub
   output logic HUB_REQ_VLD,
   output logic HUB_REQ_RD,
   output logic [ADDR_W-1:0] HUB_REQ_ADDR,
   output logic [DATA_W-1:0] HUB_REQ_DATA,
   input wire logic HUB_REQ_RDY,
   // Read return from the hub
   input wire logic HUB_RET_VLD,
   input wire logic [DATA_W-1:0] HUB_RET_DATA,
   // Slave requests from the hub
   input wire logic SLV_REQ_VLD,
   input wire logic SLV_REQ_RD,
   input wire logic [ADDR_W-1:0] SLV_REQ_ADDR,
   input wire logic [DATA_W-1:0] SLV_REQ_DATA,
   // Slave read responses
   output logic SLV_RSP_VLD,
   output logic [DATA_W-1:0] SLV_RSP_DATA,
   input wire logic SLV_RSP_STALL
);
   typedef struct packed {
      logic tck_s1;
      logic tck_s2;
      logic tck_s3;
      logic tms_s1;
      logic tms_s2;
      logic tdi_s1;
      logic tdi_s2;
      logic [ADDR_W-1:0] addr_sc;
      logic [DATA_W-1:0] wd_sc;
      logic [RDSC_W-1:0] rd_sc;
      logic rd_lock;
      logic byp;
      logic tdo;
      logic tdo_oe;
      logic [ADDR_W-1:0] hold_addr;
      logic [DATA_W-1:0] hold_data;
      logic [DATA_W-1:0] rdata;
      logic sentinel;
      logic rd_busy;
      logic go_wr;
      logic go_rd;
      logic req_vld;
      logic req_rd;
      logic [ADDR_W-1:0] req_addr;
      logic [DATA_W-1:0] req_data;
   } jub_top_reg_t;

   jub_top_reg_t s_q;
   jub_top_reg_t s_d;

   logic tck_rise;
   logic tck_fall;
   jub_tap_state_t tap_st;
   logic [IR_W-1:0] ir;
   logic ir_tdo;
   logic cap_dr;
   logic shift_dr;
   logic upd_dr;
   logic upd_ir;
   logic is_addr;
   logic is_data;
   logic is_rdata;
   logic ctrl_en;
   logic start_wr;
   logic start_rd;
   logic tdo_sel;
   logic [DATA_W-1:0] status;
   logic [DATA_W-1:0] ctrl;

   // TMS and TDI feed logic from their second stage; TCK edges compare its second and third stages
   assign tck_rise = s_q.tck_s2 && !s_q.tck_s3;
   assign tck_fall = !s_q.tck_s2 && s_q.tck_s3;

   jub_tap jub_tap_i (
      .clk(REF_CLK),
      .rst(RST),
      .tck_rise(tck_rise),
      .tms(s_q.tms_s2),
      .tdi(s_q.tdi_s2),
      .state(tap_st),
      .ir(ir),
      .ir_tdo(ir_tdo),
      .cap_dr(cap_dr),
      .shift_dr(shift_dr),
      .upd_dr(upd_dr),
      .upd_ir(upd_ir)
   );

   // Instruction decode
   assign is_addr = (ir == IR_ADDR_LOAD) || (ir == IR_ADDR_WRITE) || (ir == IR_ADDR_READ);
   assign is_data = (ir == IR_WDATA_LOAD) || (ir == IR_DATA_WRITE);
   assign is_rdata = (ir == IR_RDATA);
   assign ctrl_en = ctrl[CTRL_EN_BIT];

   // Starts are not checked against a busy bus; the host serialises them
   assign start_wr = ctrl_en && ((upd_ir && (ir == IR_START_WRITE)) || s_q.go_wr);
   assign start_rd = ctrl_en && ((upd_ir && (ir == IR_START_READ)) || s_q.go_rd);

   always_comb begin
      tdo_sel = s_q.byp;
      if (tap_st == TAP_SHIFT_IR) begin
         tdo_sel = ir_tdo;
      end else if (is_addr) begin
         tdo_sel = s_q.addr_sc[0];
      end else if (is_data) begin
         tdo_sel = s_q.wd_sc[0];
      end else if (is_rdata) begin
         tdo_sel = s_q.rd_sc[RDSC_W-1];
      end
   end

   always_comb begin
      status = '0;
      status[ST_SENTINEL] = s_q.sentinel;
      status[ST_RD_BUSY] = s_q.rd_busy;
      status[ST_REQ_PEND] = s_q.req_vld;
      status[ST_IR_LSB +: IR_W] = ir;
   end

   always_comb begin
      s_d = s_q;
      s_d.tck_s1 = TCK;
      s_d.tck_s2 = s_q.tck_s1;
      s_d.tck_s3 = s_q.tck_s2;
      s_d.tms_s1 = TMS;
      s_d.tms_s2 = s_q.tms_s1;
      s_d.tdi_s1 = TDI;
      s_d.tdi_s2 = s_q.tdi_s1;
      s_d.go_wr = 1'b0;
      s_d.go_rd = 1'b0;

      // Capture-DR
      if (cap_dr) begin
         if (is_rdata) begin
            s_d.rd_sc = {s_q.sentinel, s_q.rdata};
            s_d.rd_lock = s_q.sentinel;
         end else if (!is_addr && !is_data) begin
            s_d.byp = 1'b0;
         end
      end

      // Shift-DR, least significant bit first for loads
      if (shift_dr) begin
         if (is_addr) begin
            s_d.addr_sc = {s_q.tdi_s2, s_q.addr_sc[ADDR_W-1:1]};
         end else if (is_data) begin
            s_d.wd_sc = {s_q.tdi_s2, s_q.wd_sc[DATA_W-1:1]};
         end else if (is_rdata) begin
            // Reload until the sentinel is caught, so a late return still shows
            if (s_q.rd_lock) begin
               s_d.rd_sc = {s_q.rd_sc[RDSC_W-2:0], s_q.tdi_s2};
            end else begin
               s_d.rd_sc = {s_q.sentinel, s_q.rdata};
               s_d.rd_lock = s_q.sentinel;
            end
         end else begin
            s_d.byp = s_q.tdi_s2;
         end
      end

      // Update-DR moves scan contents into the holding registers
      if (upd_dr) begin
         if (is_addr) begin
            s_d.hold_addr = s_q.addr_sc;
         end
         if (is_data) begin
            s_d.hold_data = s_q.wd_sc;
         end
         s_d.go_wr = (ir == IR_ADDR_WRITE) || (ir == IR_DATA_WRITE);
         s_d.go_rd = (ir == IR_ADDR_READ);
      end

      // TDO changes on the falling edge, half a period before the host samples
      if (tck_fall) begin
         s_d.tdo = tdo_sel;
         s_d.tdo_oe = (tap_st == TAP_SHIFT_DR) || (tap_st == TAP_SHIFT_IR);
      end

      // Hub request handshake
      if (s_q.req_vld && HUB_REQ_RDY) begin
         s_d.req_vld = 1'b0;
      end

      // Read return; there is no error path, the host times out instead
      if (HUB_RET_VLD && s_q.rd_busy) begin
         s_d.rdata = HUB_RET_DATA;
         s_d.sentinel = 1'b1;
         s_d.rd_busy = 1'b0;
      end

      if (start_wr) begin
         s_d.req_vld = 1'b1;
         s_d.req_rd = 1'b0;
         s_d.req_addr = s_q.hold_addr;
         s_d.req_data = s_q.hold_data;
      end

      if (start_rd) begin
         s_d.req_vld = 1'b1;
         s_d.req_rd = 1'b1;
         s_d.req_addr = s_q.hold_addr;
         s_d.sentinel = 1'b0;
         s_d.rd_busy = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Local registers are reached only from the bus, never from the scan path
   jub_slave jub_slave_i (
      .clk(REF_CLK),
      .rst(RST),
      .req_vld(SLV_REQ_VLD),
      .req_rd(SLV_REQ_RD),
      .req_ofs(SLV_REQ_ADDR[LR_OFS_W-1:0]),
      .req_data(SLV_REQ_DATA),
      .rsp_vld(SLV_RSP_VLD),
      .rsp_data(SLV_RSP_DATA),
      .rsp_stall(SLV_RSP_STALL),
      .status(status),
      .hold_addr(s_q.hold_addr),
      .hold_data(s_q.hold_data),
      .rdata(s_q.rdata),
      .ctrl(ctrl)
   );

   assign TDO = s_q.tdo;
   assign TDO_OE = s_q.tdo_oe;
   assign HUB_REQ_VLD = s_q.req_vld;
   assign HUB_REQ_RD = s_q.req_rd;
   assign HUB_REQ_ADDR = s_q.req_addr;
   assign HUB_REQ_DATA = s_q.req_data;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   chk_addr_hold_copy: assert property (
      upd_dr && is_addr |=> s_q.hold_addr == $past(s_q.addr_sc))
      else $error("address holding register not loaded");
   chk_data_hold_copy: assert property (
      upd_dr && is_data |=> s_q.hold_data == $past(s_q.wd_sc))
      else $error("data holding register not loaded");
   chk_sentinel_busy: assert property (
      s_q.rd_busy |-> !s_q.sentinel)
      else $error("sentinel set while read outstanding");
   chk_sentinel_return: assert property (
      HUB_RET_VLD && s_q.rd_busy && !start_rd
      |=> s_q.sentinel && (s_q.rdata == $past(HUB_RET_DATA)))
      else $error("read return not captured");
   chk_read_start: assert property (
      start_rd |=> !s_q.sentinel && s_q.rd_busy && HUB_REQ_VLD && HUB_REQ_RD)
      else $error("read start did not issue or clear sentinel");
   chk_write_start: assert property (
      upd_ir && (ir == IR_START_WRITE) && ctrl_en
      |=> HUB_REQ_VLD && !HUB_REQ_RD && (HUB_REQ_ADDR == $past(s_q.hold_addr)))
      else $error("write start did not issue");
   chk_combo_write: assert property (
      upd_dr && ((ir == IR_ADDR_WRITE) || (ir == IR_DATA_WRITE)) && ctrl_en
      |=> !HUB_REQ_VLD || HUB_REQ_RDY ##1 HUB_REQ_VLD && !HUB_REQ_RD
         && (HUB_REQ_DATA == s_q.hold_data))
      else $error("combined write not issued two cycles after update");
   chk_combo_read: assert property (
      upd_dr && (ir == IR_ADDR_READ) && ctrl_en
      |=> 1'b1 ##1 HUB_REQ_VLD && HUB_REQ_RD && (HUB_REQ_ADDR == s_q.hold_addr))
      else $error("combined read not issued two cycles after update");
   chk_rdata_capture: assert property (
      cap_dr && is_rdata |=> s_q.rd_sc == {$past(s_q.sentinel), $past(s_q.rdata)})
      else $error("read scan register not captured with sentinel");
endmodule
`default_nettype wire

// ### dv/jub_hub_model.sv
// Behavioural model of the noncacheable hub on the bridge master port
`timescale 1ns/1ps
`default_nettype none
module jub_hub_model
   import jub_pkg::*;
(
   // Clock, reset and pace
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   // Master requests
   input wire logic req_vld,
   input wire logic req_rd,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_data,
   output logic req_rdy,
   // Read return
   output logic ret_vld,
   output logic [DATA_W-1:0] ret_data,
   // Last accepted request
   output int seen_cnt,
   output logic seen_rd,
   output logic [ADDR_W-1:0] seen_addr,
   output logic [DATA_W-1:0] seen_data
);
   int wait_q;
   int ret_q;
   logic [DATA_W-1:0] val_q;
   always @(posedge clk) begin
      ret_vld <= 1'b0;
      // Return data changes every idle cycle so a stale capture shows up
      ret_data <= ~ret_data;
      if (rst) begin
         req_rdy <= 1'b0;
         wait_q <= 0;
         ret_q <= 0;
         seen_cnt <= 0;
         ret_data <= 64'h0;
      end else begin
         req_rdy <= req_vld && !req_rdy && (wait_q >= (slow ? 4 : 0));
         wait_q <= (req_vld && !req_rdy) ? wait_q + 1 : 0;
         if (req_vld && req_rdy) begin
            seen_cnt <= seen_cnt + 1;
            seen_rd <= req_rd;
            seen_addr <= req_addr;
            seen_data <= req_data;
            if (req_rd) begin
               ret_q <= slow ? 150 : 10;
               val_q <= {24'hC3A596, req_addr};
            end
         end else if (ret_q == 1) begin
            ret_vld <= 1'b1;
            ret_data <= val_q;
            ret_q <= 0;
         end else if (ret_q > 1) begin
            ret_q <= ret_q - 1;
         end
      end
   end
endmodule
`default_nettype wire

// ### dv/jub_bridge_tb.sv
// Self-checking bench of the JTAG to unit bus bridge
`timescale 1ns/1ps
`default_nettype none
module jub_bridge_tb
   import jub_pkg::*;
;
   logic clk, rst, tck, tms, tdi, tdo, tdo_oe, tdo_s, slow;
   logic hvld, hrd, hrdy, rvld, svld, srd, rspv, stall, seen_rd;
   logic [ADDR_W-1:0] haddr, saddr, seen_addr;
   logic [DATA_W-1:0] hdata, rdat, sdata, rspd, seen_data, got;
   int seen_cnt, resps;
   int miscompares = 0;
   int total_checks = 0;
   localparam logic [ADDR_W-1:0] A1 = 40'h12_3456_789A;
   localparam logic [ADDR_W-1:0] A2 = 40'h80_0000_0008;
   localparam logic [ADDR_W-1:0] A3 = 40'hFF_FFFF_FFF8;
   localparam logic [DATA_W-1:0] D1 = 64'hFEDC_BA98_7654_3210;
   localparam logic [DATA_W-1:0] D2 = 64'h8000_0000_0000_0001;
   localparam logic [DATA_W-1:0] ST_AFTER_RD = (64'(IR_RDATA) << ST_IR_LSB) | (64'h1 << ST_SENTINEL);
   jub_bridge jub_bridge_i (.REF_CLK(clk), .RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi),
      .TDO(tdo), .TDO_OE(tdo_oe), .HUB_REQ_VLD(hvld), .HUB_REQ_RD(hrd),
      .HUB_REQ_ADDR(haddr), .HUB_REQ_DATA(hdata), .HUB_REQ_RDY(hrdy),
      .HUB_RET_VLD(rvld), .HUB_RET_DATA(rdat), .SLV_REQ_VLD(svld), .SLV_REQ_RD(srd),
      .SLV_REQ_ADDR(saddr), .SLV_REQ_DATA(sdata), .SLV_RSP_VLD(rspv),
      .SLV_RSP_DATA(rspd), .SLV_RSP_STALL(stall));
   jub_hub_model jub_hub_model_i (.clk(clk), .rst(rst), .slow(slow), .req_vld(hvld),
      .req_rd(hrd), .req_addr(haddr), .req_data(hdata), .req_rdy(hrdy), .ret_vld(rvld),
      .ret_data(rdat), .seen_cnt(seen_cnt), .seen_rd(seen_rd), .seen_addr(seen_addr),
      .seen_data(seen_data));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [DATA_W-1:0] exp,
      input logic [DATA_W-1:0] act);
      total_checks++;
      if (act !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", nm, exp, act);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic fail(input string nm);
      miscompares++;
      $display("unexpected %s: expected completion seen timeout", nm);
      end_sim();
   endtask
   // One 400 ns link clock period; TDO sampled just before the rise
   task automatic tck_step(input logic m, input logic d);
      tms = m;
      tdi = d;
      repeat (2) @(negedge clk);
      tdo_s = tdo;
      tck = 1'b1;
      repeat (4) @(negedge clk);
      tck = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   // From Idle through one shift, LSB first, back to Idle
   task automatic scan(input logic ir_path, input int nb, input logic [DATA_W-1:0] din);
      tck_step(1'b1, 1'b0);
      if (ir_path) tck_step(1'b1, 1'b0);
      tck_step(1'b0, 1'b0);
      tck_step(1'b0, 1'b0);
      for (int i = 0; i < nb; i++) tck_step(i == nb - 1, din[i]);
      tck_step(1'b1, 1'b0);
      tck_step(1'b0, 1'b0);
   endtask
   // Instruction, optional data scan, then exactly one hub request expected
   task automatic op(input logic [IR_W-1:0] code, input int nb, input logic [DATA_W-1:0] din,
      input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int base;
      int k;
      base = seen_cnt;
      scan(1'b1, IR_W, 64'(code));
      if (nb > 0) scan(1'b0, nb, din);
      k = 0;
      while (seen_cnt == base && k < 60) begin
         @(negedge clk);
         k++;
      end
      if (k == 60) fail("hub request");
      chk("hub request count", 64'(base + 1), 64'(seen_cnt));
      chk("hub request kind", 64'(rd), 64'(seen_rd));
      chk("hub request address", 64'(a), 64'(seen_addr));
      if (!rd) chk("hub write data", d, seen_data);
   endtask
   task automatic poll(input logic [ADDR_W-1:0] a);
      int k;
      scan(1'b1, IR_W, 64'(IR_RDATA));
      tck_step(1'b1, 1'b0);
      tck_step(1'b0, 1'b0);
      tck_step(1'b0, 1'b0);
      k = 0;
      do begin
         tck_step(1'b0, 1'b0);
         if (k == 0) chk("sentinel while pending", 64'h0, 64'(tdo_s));
         if (k == 0) chk("output enable in shift", 64'h1, 64'(tdo_oe));
         k++;
      end while (tdo_s !== 1'b1 && k < 400);
      if (tdo_s !== 1'b1) fail("read sentinel");
      for (int i = 63; i >= 0; i--) begin
         tck_step(i == 0, 1'b0);
         got[i] = tdo_s;
      end
      tck_step(1'b1, 1'b0);
      tck_step(1'b0, 1'b0);
      chk("read data", {24'hC3A596, a}, got);
   endtask
   task automatic slv(input logic rd, input logic [7:0] ofs, input logic [DATA_W-1:0] d);
      svld = 1'b1;
      srd = rd;
      saddr = {32'h0, ofs};
      sdata = d;
      @(negedge clk);
      svld = 1'b0;
      saddr = ~saddr;
      sdata = ~sdata;
      // An idle cycle keeps the next call from raising the strobe at once
      @(negedge clk);
   endtask
   task automatic slv_rd(input logic [7:0] ofs, input logic [DATA_W-1:0] exp, input string nm);
      int k;
      slv(1'b1, ofs, 64'h0);
      k = 0;
      while (rspv !== 1'b1 && k < 20) begin
         @(negedge clk);
         k++;
      end
      if (k == 20) fail(nm);
      chk(nm, exp, rspd);
      @(negedge clk);
   endtask
   initial begin
      {rst, tck, tms, tdi, svld, srd, stall} = 7'h40;
      {saddr, sdata} = 104'h0;
      slow = 1'b1;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      for (int i = 0; i < 6; i++) tck_step(i < 5, 1'b0);
      chk("output enable idle", 64'h0, 64'(tdo_oe));
      slv_rd(LR_CTRL, CTRL_RST, "control reset");
      slv(1'b0, 8'h48, 64'h0);
      slv_rd(LR_CTRL, CTRL_RST, "control after undefined write");
      slv_rd(8'h40, UNDEF_RDATA, "undefined read");
      $display("test local registers done");
      scan(1'b1, IR_W, 64'(IR_ADDR_LOAD));
      scan(1'b0, ADDR_W, 64'(A1));
      scan(1'b1, IR_W, 64'(IR_WDATA_LOAD));
      scan(1'b0, DATA_W, D1);
      chk("no request on load", 64'h0, 64'(seen_cnt));
      slv_rd(LR_HOLD_ADDR, 64'(A1), "hold address");
      slv_rd(LR_HOLD_DATA, D1, "hold data");
      $display("test holding registers done");
      op(IR_START_WRITE, 0, 64'h0, 1'b0, A1, D1);
      op(IR_ADDR_WRITE, ADDR_W, 64'(A2), 1'b0, A2, D1);
      op(IR_DATA_WRITE, DATA_W, D2, 1'b0, A2, D2);
      $display("test writes done");
      op(IR_START_READ, 0, 64'h0, 1'b1, A2, 64'h0);
      poll(A2);
      op(IR_ADDR_READ, ADDR_W, 64'(A3), 1'b1, A3, 64'h0);
      poll(A3);
      slv_rd(LR_RDATA, {24'hC3A596, A3}, "read data register");
      slv_rd(LR_STATUS, ST_AFTER_RD, "status after read");
      slow = 1'b0;
      op(IR_START_WRITE, 0, 64'h0, 1'b0, A3, D2);
      $display("test reads done");
      // Four back-to-back reads against a long stall
      stall = 1'b1;
      svld = 1'b1;
      srd = 1'b1;
      saddr = 40'(LR_CTRL);
      repeat (4) @(negedge clk);
      svld = 1'b0;
      repeat (6) @(negedge clk);
      resps = (rspv === 1'b1) ? 1 : 0;
      chk("held response", CTRL_RST, rspd);
      stall = 1'b0;
      repeat (12) begin
         @(negedge clk);
         if (rspv === 1'b1) resps++;
      end
      // One slot: the first read answers, the second waits, the rest drop
      chk("stalled requests answered", 64'h2, 64'(resps));
      $display("test stall done");
      end_sim();
   end
endmodule
`default_nettype wire
